// [msli_led_model.sv]
// Purpose: model of the status lamp seen from outside
// Assumes: colour and level codes of msli_pkg and msli_map.svh
// Notes: a lamp at level zero shows no colour at all
`timescale 1ns/1ns
`default_nettype none
module msli_led_model
    import msli_pkg::*;
(
    input wire logic [1:0] led_colour,
    input wire logic [1:0] led_bright,
    output logic [1:0] seen_colour,
    output logic [1:0] seen_level
);
    // a dark lamp hides whatever colour code is presented
    assign seen_level = led_bright;
    assign seen_colour = (led_bright == 2'h0) ? MSLI_OFF : led_colour;
endmodule
`default_nettype wire

// [msli_map.svh]
// Purpose: constants for the status indicator block
// Assumes: 125 MHz module clock
// Notes: times in ms, counts derived from them
`ifndef MSLI_MAP_SVH
`define MSLI_MAP_SVH
`define MSLI_CLK_KHZ 125000
`define MSLI_T_250_MS 250
`define MSLI_T_100_MS 100
`define MSLI_T_500_MS 500
`define MSLI_T_600_MS 600
`define MSLI_T_1900_MS 1900
`define MSLI_TICK_CYC (`MSLI_CLK_KHZ * 1)
`define MSLI_N_CH 4
`define MSLI_BR_OFF 2'h0
`define MSLI_BR_RED 2'h1
`define MSLI_BR_SEMI 2'h2
`define MSLI_BR_FULL 2'h3
`endif

// [msli_phase_timer.sv]
// Purpose: millisecond tick and phase counter for blink patterns
// Assumes: 125 MHz clock
// Notes: phase restarts when the pattern changes
`timescale 1ns/1ns
`default_nettype none
`include "msli_map.svh"
module msli_phase_timer (
    input wire logic clock,
    input wire logic reset,
    input wire logic restart,
    output logic [11:0] ms_count
);
    logic [16:0] div_r;
    logic tick;
    assign tick = (div_r == 17'(`MSLI_TICK_CYC - 1));
    always_ff @(posedge clock) begin
        if (reset || restart || tick) begin
            div_r <= 17'h0;
        end else begin
            div_r <= div_r + 17'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (reset || restart) begin
            ms_count <= 12'h0;
        end else if (tick) begin
            ms_count <= ms_count + 12'h1;
        end
    end
endmodule
`default_nettype wire

// [msli_pkg.sv]
// Purpose: types for the status indicator block
// Assumes: nothing
// Notes: colour and mode encodings
package msli_pkg;
    typedef enum logic [1:0] {
        MSLI_OFF = 2'h0,
        MSLI_GREEN = 2'h1,
        MSLI_YELLOW = 2'h2,
        MSLI_RED = 2'h3
    } msli_colour_t;
    typedef enum logic [9:0] {
        MSLI_S_DARK = 10'h001,
        MSLI_S_INIT = 10'h002,
        MSLI_S_NORM = 10'h004,
        MSLI_S_SUPP = 10'h008,
        MSLI_S_STBY = 10'h010,
        MSLI_S_IDENT = 10'h020,
        MSLI_S_FWUP = 10'h040,
        MSLI_S_OVLD = 10'h080,
        MSLI_S_STERR = 10'h100,
        MSLI_S_INTERR = 10'h200
    } msli_state_t;
endpackage

// [msli_status_led.sv]
// Function
// RL1 - dark whenever module power is absent
// RL2 - init incomplete: yellow 0.25 s normal/reduced
// RL3 - normal operation: steady green semi bright
// RL4 - any sensor supply on: steady yellow semi
// RL5 - standby no link: green 0.1 on/1.9 off
// RL6 - identification: red 0.25 s normal/reduced
// RL7 - firmware update: red 0.1 on/0.6 off
// RL8 - overload: yellow reduced / red reduced 0.5 s
// RL9 - self-test red full; internal error red semi
// RL10 - short circuit switches off that channel only
// RL11 - per-channel readable fault report
//
// Purpose: status LED colour/brightness and sensor supply protection
// Assumes: condition inputs come from pins or other clocks
// Notes: brightness 3=full, 2=semi, 1=reduced, 0=off
`timescale 1ns/1ns
`default_nettype none
`include "msli_map.svh"
module msli_status_led
    import msli_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic power_good,
    input wire logic init_busy,
    input wire logic standby_no_link,
    input wire logic ident_req,
    input wire logic fw_update,
    input wire logic selftest_fail,
    input wire logic internal_error,
    input wire logic [3:0] supply_enable_req,
    input wire logic [3:0] supply_short,
    input wire logic [3:0] supply_fuse_blown,
    input wire logic [3:0] fault_clear,
    output logic [1:0] led_colour,
    output logic [1:0] led_bright,
    output logic [3:0] supply_on,
    output logic [3:0] supply_fault,
    output logic overload_warn
);
    logic [18:0] s1_r, s2_r;
    msli_state_t state_r, state_nxt;
    logic [11:0] ms_count;
    logic restart;
    logic [1:0] colour_nxt, bright_nxt;
    logic [3:0] latch_off_r;

    // every condition is asynchronous to the module clock
    always_ff @(posedge clock) begin
        if (reset) begin
            s1_r <= 19'h0;
            s2_r <= 19'h0;
        end else begin
            s1_r <= {power_good, init_busy, standby_no_link, ident_req, fw_update, selftest_fail,
                     internal_error, supply_enable_req, supply_short, supply_fuse_blown};
            s2_r <= s1_r;
        end
    end

    logic pg_s, init_s, stby_s, ident_s, fw_s, st_s, ie_s;
    logic [3:0] en_s, short_s, fuse_s;
    assign {pg_s, init_s, stby_s, ident_s, fw_s, st_s, ie_s, en_s, short_s, fuse_s} = s2_r;

    // a shorted channel stays off until software acknowledges its fault
    genvar g;
    generate
        for (g = 0; g < `MSLI_N_CH; g++) begin : g_ch
            always_ff @(posedge clock) begin
                if (reset) begin
                    latch_off_r[g] <= 1'b0;
                end else if (short_s[g] || fuse_s[g]) begin
                    latch_off_r[g] <= 1'b1; // RL10
                end else if (fault_clear[g]) begin
                    latch_off_r[g] <= 1'b0;
                end
            end
            always_ff @(posedge clock) begin
                if (reset) begin
                    supply_on[g] <= 1'b0;
                    supply_fault[g] <= 1'b0;
                end else begin
                    supply_on[g] <= pg_s && en_s[g] && !latch_off_r[g] && !short_s[g]; // RL10
                    // set wins over clear
                    supply_fault[g] <= short_s[g] || fuse_s[g] || (supply_fault[g] && !fault_clear[g]); // RL11
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (reset) begin
            overload_warn <= 1'b0;
        end else begin
            overload_warn <= |(latch_off_r | short_s | fuse_s);
        end
    end

    // priority: no power, errors, service, overload, init, standby, supply, normal
    always_comb begin
        state_nxt = MSLI_S_NORM; // RL3
        if (!pg_s) begin
            state_nxt = MSLI_S_DARK; // RL1
        end else if (st_s) begin
            state_nxt = MSLI_S_STERR; // RL9
        end else if (ie_s) begin
            state_nxt = MSLI_S_INTERR; // RL9
        end else if (fw_s) begin
            state_nxt = MSLI_S_FWUP; // RL7
        end else if (ident_s) begin
            state_nxt = MSLI_S_IDENT; // RL6
        end else if (|(latch_off_r | short_s | fuse_s)) begin
            state_nxt = MSLI_S_OVLD; // RL8
        end else if (init_s) begin
            state_nxt = MSLI_S_INIT; // RL2
        end else if (stby_s) begin
            state_nxt = MSLI_S_STBY; // RL5
        end else if (|supply_on) begin
            state_nxt = MSLI_S_SUPP; // RL4
        end
    end

    // each blink pattern restarts at its own period, so the 12-bit count never wraps mid-pattern
    function automatic logic [11:0] period_ms(input msli_state_t st);
        case (st)
            MSLI_S_INIT, MSLI_S_IDENT: period_ms = 12'(2 * `MSLI_T_250_MS);
            MSLI_S_STBY: period_ms = 12'(`MSLI_T_100_MS + `MSLI_T_1900_MS);
            MSLI_S_FWUP: period_ms = 12'(`MSLI_T_100_MS + `MSLI_T_600_MS);
            MSLI_S_OVLD: period_ms = 12'(2 * `MSLI_T_500_MS);
            default: period_ms = 12'hfff;
        endcase
    endfunction

    // the period boundary lasts one cycle, so each period is one clock longer than nominal
    assign restart = (state_nxt != state_r) || (ms_count == period_ms(state_r)); // RL5

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= MSLI_S_DARK;
        end else begin
            state_r <= state_nxt;
        end
    end

    msli_phase_timer u_timer (
        .clock(clock),
        .reset(reset),
        .restart(restart),
        .ms_count(ms_count)
    );

    function automatic logic in_window(input logic [11:0] ms, input logic [11:0] on_ms, input logic [11:0] per_ms);
        in_window = (ms % per_ms) < on_ms;
    endfunction

    always_comb begin
        colour_nxt = 2'(MSLI_OFF);
        bright_nxt = `MSLI_BR_OFF;
        case (state_r)
            MSLI_S_DARK: begin
                colour_nxt = 2'(MSLI_OFF); // RL1
                bright_nxt = `MSLI_BR_OFF;
            end
            MSLI_S_INIT: begin
                colour_nxt = 2'(MSLI_YELLOW); // RL2
                bright_nxt = in_window(ms_count, 12'(`MSLI_T_250_MS), 12'(2 * `MSLI_T_250_MS)) ?
                             `MSLI_BR_FULL : `MSLI_BR_RED;
            end
            MSLI_S_NORM: begin
                colour_nxt = 2'(MSLI_GREEN); // RL3
                bright_nxt = `MSLI_BR_SEMI;
            end
            MSLI_S_SUPP: begin
                colour_nxt = 2'(MSLI_YELLOW); // RL4
                bright_nxt = `MSLI_BR_SEMI;
            end
            MSLI_S_STBY: begin
                colour_nxt = 2'(MSLI_GREEN); // RL5
                bright_nxt = in_window(ms_count, 12'(`MSLI_T_100_MS), 12'(`MSLI_T_100_MS + `MSLI_T_1900_MS)) ?
                             `MSLI_BR_FULL : `MSLI_BR_OFF;
            end
            MSLI_S_IDENT: begin
                colour_nxt = 2'(MSLI_RED); // RL6
                bright_nxt = in_window(ms_count, 12'(`MSLI_T_250_MS), 12'(2 * `MSLI_T_250_MS)) ?
                             `MSLI_BR_FULL : `MSLI_BR_RED;
            end
            MSLI_S_FWUP: begin
                colour_nxt = 2'(MSLI_RED); // RL7
                bright_nxt = in_window(ms_count, 12'(`MSLI_T_100_MS), 12'(`MSLI_T_100_MS + `MSLI_T_600_MS)) ?
                             `MSLI_BR_FULL : `MSLI_BR_OFF;
            end
            MSLI_S_OVLD: begin
                colour_nxt = in_window(ms_count, 12'(`MSLI_T_500_MS), 12'(2 * `MSLI_T_500_MS)) ?
                             2'(MSLI_YELLOW) : 2'(MSLI_RED); // RL8
                bright_nxt = `MSLI_BR_RED;
            end
            MSLI_S_STERR: begin
                colour_nxt = 2'(MSLI_RED); // RL9
                bright_nxt = `MSLI_BR_FULL;
            end
            MSLI_S_INTERR: begin
                colour_nxt = 2'(MSLI_RED); // RL9
                bright_nxt = `MSLI_BR_SEMI;
            end
            default: begin
                colour_nxt = 2'(MSLI_OFF);
                bright_nxt = `MSLI_BR_OFF;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            led_colour <= 2'(MSLI_OFF);
            led_bright <= `MSLI_BR_OFF;
        end else begin
            led_colour <= colour_nxt;
            led_bright <= bright_nxt;
        end
    end

    property p_dark;
        @(posedge clock) disable iff (reset) (state_r == MSLI_S_DARK) |=> (led_bright == `MSLI_BR_OFF);
    endproperty
    a_dark: assert property (p_dark) else $error("led lit without power"); // RL1
    property p_semi_green;
        @(posedge clock) disable iff (reset)
            (state_r == MSLI_S_NORM) |=> (led_colour == 2'(MSLI_GREEN) && led_bright == `MSLI_BR_SEMI);
    endproperty
    a_semi_green: assert property (p_semi_green) else $error("normal not green semi"); // RL3
    property p_supp;
        @(posedge clock) disable iff (reset)
            (state_r == MSLI_S_SUPP) |=> (led_colour == 2'(MSLI_YELLOW) && led_bright == `MSLI_BR_SEMI);
    endproperty
    a_supp: assert property (p_supp) else $error("supply state not yellow semi"); // RL4
    sequence s_short_seen;
        (short_s != 4'h0);
    endsequence
    property p_short_off;
        @(posedge clock) disable iff (reset) s_short_seen |=> ((supply_on & $past(short_s)) == 4'h0);
    endproperty
    a_short_off: assert property (p_short_off) else $error("shorted supply still on"); // RL10
    property p_fault;
        @(posedge clock) disable iff (reset) (short_s[1] || fuse_s[1]) |=> supply_fault[1];
    endproperty
    a_fault: assert property (p_fault) else $error("fault not reported"); // RL11
    property p_sterr;
        @(posedge clock) disable iff (reset)
            (state_r == MSLI_S_STERR) |=> (led_bright == `MSLI_BR_FULL && led_colour == 2'(MSLI_RED));
    endproperty
    a_sterr: assert property (p_sterr) else $error("self-test not red full"); // RL9
    property p_ovld;
        @(posedge clock) disable iff (reset) (state_r == MSLI_S_OVLD) |=> (led_bright == `MSLI_BR_RED);
    endproperty
    a_ovld: assert property (p_ovld) else $error("overload not reduced"); // RL8
    property p_init_start;
        @(posedge clock) disable iff (reset)
            (state_r == MSLI_S_INIT && ms_count == 12'h0) |=> (led_bright == `MSLI_BR_FULL);
    endproperty
    a_init_start: assert property (p_init_start) else $error("init blink not bright first"); // RL2
endmodule
`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench for the status indicator block
// Assumes: 125 MHz clock, inputs other than fault_clear pass a 2-stage synchroniser
// Notes: blink periods need millions of cycles, so only first phases are seen
`timescale 1ns/1ns
`default_nettype none
`include "msli_map.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
    import msli_pkg::*;
    localparam logic [1:0] EC [6] = '{MSLI_YELLOW, MSLI_GREEN, MSLI_RED, MSLI_RED, MSLI_RED, MSLI_RED};
    localparam logic [1:0] EB [6] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h2};
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic power_good = 1'b0;
    logic [5:0] modes = 6'h0;
    logic [3:0] enable_req = 4'h0;
    logic [3:0] short_in = 4'h0;
    logic [3:0] fuse_in = 4'h0;
    logic [3:0] clear_in = 4'h0;
    logic [1:0] led_colour;
    logic [1:0] led_bright;
    logic [1:0] seen_colour;
    logic [1:0] seen_level;
    logic [3:0] supply_on;
    logic [3:0] supply_fault;
    logic overload_warn;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    always #4 clock = ~clock;
    msli_status_led u_dut (.clock(clock), .reset(reset), .power_good(power_good),
        .init_busy(modes[0]), .standby_no_link(modes[1]), .ident_req(modes[2]),
        .fw_update(modes[3]), .selftest_fail(modes[4]), .internal_error(modes[5]),
        .supply_enable_req(enable_req), .supply_short(short_in), .supply_fuse_blown(fuse_in),
        .fault_clear(clear_in), .led_colour(led_colour), .led_bright(led_bright),
        .supply_on(supply_on), .supply_fault(supply_fault), .overload_warn(overload_warn));
    msli_led_model u_lamp (.led_colour(led_colour), .led_bright(led_bright),
        .seen_colour(seen_colour), .seen_level(seen_level));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            final_report();
        end
    end
    // inputs always change 1 ns after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic t_dark();
        modes = 6'h08;
        enable_req = 4'h1;
        step(8);
        `CHK("lamp level", 2'h0, seen_level);
        `CHK("lamp colour", MSLI_OFF, seen_colour);
        `CHK("supply refused", 4'h0, supply_on);
        modes = 6'h0;
        enable_req = 4'h0;
        $display("test dark done");
    endtask
    task automatic t_normal();
        power_good = 1'b1;
        step(8);
        `CHK("normal colour", MSLI_GREEN, seen_colour);
        `CHK("normal level", `MSLI_BR_SEMI, seen_level);
        $display("test normal done");
    endtask
    task automatic t_supply_fault();
        enable_req = 4'h6;
        step(8);
        `CHK("supply on", 4'h6, supply_on);
        `CHK("supply colour", MSLI_YELLOW, seen_colour);
        `CHK("supply level", `MSLI_BR_SEMI, seen_level);
        short_in = 4'h2;
        fuse_in = 4'h8;
        step(8);
        `CHK("short off", 4'h4, supply_on);
        `CHK("fault bits", 4'ha, supply_fault);
        `CHK("overload", 1'b1, overload_warn);
        `CHK("warn colour", MSLI_YELLOW, seen_colour);
        `CHK("warn level", `MSLI_BR_RED, seen_level);
        clear_in = 4'h2;
        step(1);
        clear_in = 4'h0;
        step(2);
        // clear while the short still stands must not drop the report
        `CHK("clear refused", 4'ha, supply_fault);
        short_in = 4'h0;
        fuse_in = 4'h0;
        step(4);
        clear_in = 4'ha;
        step(1);
        clear_in = 4'h0;
        step(6);
        `CHK("fault cleared", 4'h0, supply_fault);
        `CHK("supply restored", 4'h6, supply_on);
        `CHK("overload gone", 1'b0, overload_warn);
        enable_req = 4'h0;
        step(8);
        $display("test supply fault done");
    endtask
    task automatic t_reset();
        enable_req = 4'h6;
        step(8);
        reset = 1'b1;
        step(1);
        `CHK("reset level", 2'h0, seen_level);
        `CHK("reset supply", 4'h0, supply_on);
        step(1);
        reset = 1'b0;
        step(8);
        `CHK("after reset colour", MSLI_YELLOW, seen_colour);
        `CHK("after reset supply", 4'h6, supply_on);
        enable_req = 4'h0;
        step(8);
        $display("test reset done");
    endtask
    task automatic t_modes();
        for (int i = 0; i < 6; i++) begin
            modes = 6'h1 << i;
            step(8);
            `CHK("mode colour", EC[i], seen_colour);
            `CHK("mode level", EB[i], seen_level);
        end
        // self-test failure outranks every other condition except absent module power
        modes = 6'h3f;
        step(8);
        `CHK("priority colour", MSLI_RED, seen_colour);
        `CHK("priority level", 2'h3, seen_level);
        modes = 6'h0;
        step(8);
        `CHK("back normal", MSLI_GREEN, seen_colour);
        $display("test modes done");
    endtask
    initial begin
        step(4);
        reset = 1'b0;
        t_dark();
        t_normal();
        t_supply_fault();
        t_reset();
        t_modes();
        final_report();
    end
endmodule
`default_nettype wire
